// ---- design/pin_mode_ctrl.sv ----
/*
 * Holds the control-pin and supply-gating logic of an eight-channel
 * low-side driver: direct input mapping, channel OR, reset and kill pins,
 * standby pin mode selection and supply undervoltage gating.
 * Assumes a serial-interface block elsewhere writes the configuration
 * through the strobed ports and honours the availability outputs.
 */

// Mapping reset values and the synchroniser depth come from the shared header.
`include "pin_mode_consts.svh"
module pin_mode_ctrl
	import pin_mode_pkg::*;
#(
	parameter int CHANNELS = `CHANNEL_COUNT
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Direct input pins.
	input wire logic direct_input_a_in,
	input wire logic direct_input_b_in,
	// Standby-select pin, low asks for sleep or limp-home.
	input wire logic standby_select_in,
	// Output-kill pin, high kills channels when enabled.
	input wire logic output_kill_pin_in,
	// External reset pin, active low.
	input wire logic external_reset_pin_n_in,
	// Supply undervoltage levels from the analog detectors.
	input wire logic battery_supply_uv_in,
	input wire logic io_supply_uv_in,
	// Serial write strobe and data for the mapping registers.
	input wire logic map_write_in,
	input wire pin_mode_pkg::chan_mask_t input_a_channel_map_in,
	input wire pin_mode_pkg::chan_mask_t input_b_channel_map_in,
	// Serial write strobe and data for the configuration bits.
	input wire logic cfg_write_in,
	input wire logic reset_pin_oneshot_enable_in,
	input wire logic reset_pin_persistent_enable_in,
	input wire logic kill_pin_enable_in,
	input wire logic battery_undervoltage_override_in,
	// Serial write strobe and data for the output-control bits.
	input wire logic out_write_in,
	input wire pin_mode_pkg::chan_mask_t spi_out_bits_in,
	// Mapped PWM generator outputs per channel.
	input wire pin_mode_pkg::chan_mask_t pwm_mapped_in,
	// Serial chip select, active low.
	input wire logic chip_select_n_in,
	// Channel gate drives.
	output pin_mode_pkg::chan_mask_t channel_on_out,
	// First status register bits: inputs a, b, kill pin, reset pin.
	output logic [3:0] first_status_register_out,
	// Read-back of mapping and configuration.
	output pin_mode_pkg::chan_mask_t input_a_channel_map_out,
	output pin_mode_pkg::chan_mask_t input_b_channel_map_out,
	output logic [3:0] config_out,
	// Current operating state.
	output pin_mode_pkg::mode_t mode_out,
	// High while serial transfers are accepted.
	output logic spi_available_out,
	// Output enable of the serial data pin.
	output logic serial_data_oe_out,
	// High while the supply detectors are powered.
	output logic uv_detect_enable_out,
	// High while the internal register reset is held.
	output logic register_reset_out
);
	////////////////////////////////////////////////////////////////////////
	// Synchronised pins.

	// Raw pin vector: a, b, kill, reset_n, standby.
	logic [4:0] raw_pins;
	// Synchronised copy of the pins.
	logic [4:0] sync_pins;
	// Levels the synchroniser holds under reset: kill high, reset low.
	localparam logic [4:0] PIN_SAFE = 5'h04;
	logic in_a;
	logic in_b;
	logic kill_pin;
	logic reset_pin_n;
	logic standby;

	assign raw_pins = {standby_select_in, external_reset_pin_n_in,
		output_kill_pin_in, direct_input_b_in, direct_input_a_in};

	// Every pin passes two flops before any logic sees it.
	pin_sync #(
		.WIDTH(5),
		.STAGES(`SYNC_STAGES)
	) u_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.pin_in(raw_pins),
		.reset_level_in(PIN_SAFE),
		.level_out(sync_pins)
	);

	assign in_a = sync_pins[0];
	assign in_b = sync_pins[1];
	assign kill_pin = sync_pins[2];
	assign reset_pin_n = sync_pins[3];
	assign standby = sync_pins[4];

	// Elaboration stops on a width the channel masks cannot carry; the
	// mask type is fixed by the package, so only the native width fits.
	if (CHANNELS != `CHANNEL_COUNT) begin : g_bad_width
		$error("pin_mode_ctrl serves only the native channel width");
	end

	////////////////////////////////////////////////////////////////////////
	// Mode and register reset conditions.

	// Registers held in default state.
	logic hold_regs;
	// Enabled reset pin is asserted.
	logic pin_reset;
	// Sleep condition from the pins.
	logic sleep_cond;
	// Limp-home condition from the pins.
	logic limp_cond;
	// Registered configuration bits.
	logic oneshot_en;
	logic persist_en;
	logic kill_en;
	logic uv_override;
	chan_mask_t map_a;
	chan_mask_t map_b;
	chan_mask_t spi_bits;

	// Standby and both inputs low means sleep.
	assign sleep_cond = !standby && !in_a && !in_b;
	// Standby low with an input high means limp-home.
	assign limp_cond = !standby && (in_a || in_b);
	// The reset pin counts only after an enable bit is set.
	// With only the one-shot enable set, the hold clears that enable, so
	// the pin reset lasts a single edge and the pin is masked again; the
	// host must write the enable once more to arm the pin.
	assign pin_reset = (oneshot_en || persist_en) && !reset_pin_n;
	// Sleep, IO undervoltage or pin reset holds registers.
	assign hold_regs = sleep_cond || io_supply_uv_in || pin_reset;

	// Serial writes are taken only while the interface is up.
	logic spi_ok;
	assign spi_ok = !sleep_cond && !io_supply_uv_in && !pin_reset;

	////////////////////////////////////////////////////////////////////////
	// Mapping registers, default a to channel 2 and b to channel 3.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			map_a <= `MAP_A_RESET;
			map_b <= `MAP_B_RESET;
		end else if (hold_regs) begin
			map_a <= `MAP_A_RESET;
			map_b <= `MAP_B_RESET;
		end else if (map_write_in && spi_ok) begin
			map_a <= input_a_channel_map_in;
			map_b <= input_b_channel_map_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration bits. The persistent enable survives a pin reset.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			oneshot_en <= 1'b0;
			persist_en <= 1'b0;
			kill_en <= 1'b0;
			uv_override <= 1'b0;
		end else if (hold_regs) begin
			// One-shot enable clears, masking the pin again.
			oneshot_en <= 1'b0;
			// A pin reset leaves the persistent enable alone.
			persist_en <= pin_reset && !sleep_cond && !io_supply_uv_in
				? persist_en : 1'b0;
			kill_en <= 1'b0;
			uv_override <= 1'b0;
		end else if (cfg_write_in && spi_ok) begin
			oneshot_en <= reset_pin_oneshot_enable_in;
			persist_en <= reset_pin_persistent_enable_in;
			kill_en <= kill_pin_enable_in;
			uv_override <= battery_undervoltage_override_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial output-control bits.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			spi_bits <= '0;
		end else if (hold_regs) begin
			spi_bits <= '0;
		end else if (out_write_in && spi_ok) begin
			spi_bits <= spi_out_bits_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Channel drive computation.

	// Input a owns a channel both maps claim.
	function automatic chan_mask_t input_drive(input chan_mask_t ma,
		input chan_mask_t mb, input logic a, input logic b);
		chan_mask_t only_b;
		only_b = mb & ~ma;
		return (a ? ma : '0) | (b ? only_b : '0);
	endfunction : input_drive

	chan_mask_t next_channel_on;
	always_comb begin
		next_channel_on = '0;
		if (pin_reset) begin
			next_channel_on = '0;
		end else if (kill_en && kill_pin) begin
			next_channel_on = '0;
		end else if (limp_cond) begin
			// Limp-home runs only the default input channels.
			next_channel_on = input_drive(`MAP_A_RESET, `MAP_B_RESET,
				in_a, in_b);
			if (battery_supply_uv_in) begin
				next_channel_on = '0;
			end
		end else if (!sleep_cond) begin
			// Kill pin low or masked leaves the drive untouched.
			next_channel_on = spi_bits | pwm_mapped_in |
				input_drive(map_a, map_b, in_a, in_b);
			if (battery_supply_uv_in && !uv_override) begin
				next_channel_on = '0;
			end
		end
	end

	// Channel drives leave from a flop so the gate pins never glitch.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			channel_on_out <= '0;
		end else begin
			channel_on_out <= next_channel_on;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status and read-back outputs; input monitor runs in every mode.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			first_status_register_out <= 4'h0;
			input_a_channel_map_out <= `MAP_A_RESET;
			input_b_channel_map_out <= `MAP_B_RESET;
			config_out <= 4'h0;
		end else begin
			first_status_register_out <= {reset_pin_n, kill_pin,
				in_b, in_a};
			input_a_channel_map_out <= map_a;
			input_b_channel_map_out <= map_b;
			config_out <= {uv_override, kill_en, persist_en, oneshot_en};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode and availability outputs.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mode_out <= st_sleep;
			spi_available_out <= 1'b0;
			serial_data_oe_out <= 1'b0;
			uv_detect_enable_out <= 1'b0;
			register_reset_out <= 1'b1;
		end else begin
			if (sleep_cond) begin
				mode_out <= st_sleep;
			end else if (limp_cond) begin
				mode_out <= st_limp;
			end else begin
				mode_out <= st_awake;
			end
			spi_available_out <= spi_ok;
			// Data out floats in sleep even with chip select low.
			serial_data_oe_out <= spi_ok && !chip_select_n_in;
			uv_detect_enable_out <= !sleep_cond;
			register_reset_out <= hold_regs;
		end
	end
endmodule : pin_mode_ctrl

// ---- design/pin_mode_consts.svh ----
/*
 * Holds the constants of the pin and mode control block: reset values of
 * the mapping registers, the channel count and the synchroniser depth.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef PIN_MODE_CONSTS_SVH
`define PIN_MODE_CONSTS_SVH

// Default channel followed by the first direct input.
`define MAP_A_RESET 8'h04
// Default channel followed by the second direct input.
`define MAP_B_RESET 8'h08
// Default channel mask of limp-home for both inputs; the logic reads the two map defaults instead.
`define LIMP_CHANNELS 8'h0c
// Number of channels of the driver.
`define CHANNEL_COUNT 8
// Flip-flops in each pin synchroniser.
`define SYNC_STAGES 2

`endif

// ---- design/pin_mode_pkg.sv ----
/*
 * Holds the types shared by the pin and mode control block.
 * Assumes the constants header is available by bare name.
 */
`include "pin_mode_consts.svh"
package pin_mode_pkg;
	// Operating state as seen by this block.
	typedef enum logic [1:0] {
		st_sleep,
		st_limp,
		st_awake
	} mode_t;
	// One bit per output channel.
	typedef logic [`CHANNEL_COUNT-1:0] chan_mask_t;
endpackage : pin_mode_pkg

// ---- design/pin_sync.sv ----
/*
 * Holds a multi-bit two-stage synchroniser for slow pin levels.
 * Assumes each bit is an independent level, not a coded word.
 */
`include "pin_mode_consts.svh"
module pin_sync #(
	parameter int WIDTH = 4,
	parameter int STAGES = `SYNC_STAGES
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [WIDTH-1:0] pin_in,
	input wire logic [WIDTH-1:0] reset_level_in,
	output logic [WIDTH-1:0] level_out
);
	// First stage, read only by the second stage.
	logic [WIDTH-1:0] first_stage;
	// Remaining stages; the last one is the output.
	logic [WIDTH-1:0] later_stage [STAGES-1];

	// Fewer than two stages would leave metastability exposed.
	if (STAGES < 2) begin : g_bad_stages
		$error("pin_sync needs at least two stages");
	end

	////////////////////////////////////////////////////////////////////////
	// The stages clear to zero under reset; the safe level is applied by
	// XOR so each flop still takes a constant.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			first_stage <= '0;
			for (int i = 0; i < STAGES - 1; i++) begin
				later_stage[i] <= '0;
			end
		end else begin
			first_stage <= pin_in ^ reset_level_in;
			later_stage[0] <= first_stage;
			for (int i = 1; i < STAGES - 1; i++) begin
				later_stage[i] <= later_stage[i-1];
			end
		end
	end

	// Undo the XOR so the output carries the true level.
	assign level_out = later_stage[STAGES-2] ^ reset_level_in;
endmodule : pin_sync

// ---- tb/pin_mode_ctrl_properties.sv ----
/* Port checker of the pin and mode control block.
   Assumes it is bound to pin_mode_ctrl and sees only its ports. */
`include "pin_mode_consts.svh"
module pin_mode_ctrl_properties
	import pin_mode_pkg::*;
#(
	parameter int CHANNELS = `CHANNEL_COUNT
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic direct_input_a_in,
	input wire logic direct_input_b_in,
	input wire logic standby_select_in,
	input wire logic output_kill_pin_in,
	input wire logic external_reset_pin_n_in,
	input wire logic battery_supply_uv_in,
	input wire logic io_supply_uv_in,
	input wire pin_mode_pkg::chan_mask_t channel_on_out,
	input wire logic [3:0] first_status_register_out,
	input wire pin_mode_pkg::chan_mask_t input_a_channel_map_out,
	input wire pin_mode_pkg::chan_mask_t input_b_channel_map_out,
	input wire logic [3:0] config_out,
	input wire pin_mode_pkg::mode_t mode_out,
	input wire logic spi_available_out,
	input wire logic serial_data_oe_out,
	input wire logic register_reset_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	logic [2:0] age; // Edges since reset release, saturating.
	logic settled; // High once the pin pipeline holds no reset values.
	assign settled = (age == 3'h7);
	// Counts edges after reset so stale pipeline values are skipped.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			age <= 3'h0;
		end else if (age != 3'h7) begin
			age <= age + 3'h1;
		end
	end
	a_map_defaults: assert property ($past(!rst_b_in) |->
		input_a_channel_map_out == `MAP_A_RESET &&
		input_b_channel_map_out == `MAP_B_RESET) else $error("map reset");
	a_status_lag: assert property (settled && !register_reset_out &&
		!$past(register_reset_out) |-> first_status_register_out ==
		$past({external_reset_pin_n_in, output_kill_pin_in,
		direct_input_b_in, direct_input_a_in}, 3)) else $error("status");
	a_kill_forces_off: assert property ((config_out[2] &&
		output_kill_pin_in)[*4] |-> channel_on_out == '0)
		else $error("kill");
	a_sleep_entry: assert property ((!standby_select_in &&
		!direct_input_a_in && !direct_input_b_in)[*6] |->
		mode_out == st_sleep && register_reset_out) else $error("sleep");
	a_sleep_quiet: assert property (mode_out == st_sleep &&
		$past(mode_out) == st_sleep |-> !serial_data_oe_out &&
		!spi_available_out) else $error("sleep serial");
	a_io_uv_block: assert property (io_supply_uv_in[*6] |->
		!spi_available_out && config_out == 4'h0) else $error("io uv");
	a_batt_uv_off: assert property ((battery_supply_uv_in &&
		!config_out[3])[*6] |-> channel_on_out == '0)
		else $error("battery uv");
	a_pin_reset_off: assert property ((!external_reset_pin_n_in &&
		config_out[1])[*6] |-> channel_on_out == '0 && register_reset_out)
		else $error("reset pin");
	a_limp_drive: assert property ((!standby_select_in &&
		direct_input_a_in && !battery_supply_uv_in && !output_kill_pin_in &&
		external_reset_pin_n_in)[*6] |-> mode_out == st_limp &&
		channel_on_out[2]) else $error("limp");
	c_limp: cover property (mode_out == st_limp);
	c_killed: cover property (config_out[2] && channel_on_out == '0);
	c_io_uv: cover property (io_supply_uv_in && !spi_available_out);
endmodule : pin_mode_ctrl_properties

bind pin_mode_ctrl pin_mode_ctrl_properties #(.CHANNELS(CHANNELS)) u_props (.*);

// ---- tb/host_pins.sv ----
/* Host model of the standby-select pin driver.
   Assumes the bench asks for levels; each level stands at least HOLD_CYCLES plus one edges. */
module host_pins #(
	parameter int HOLD_CYCLES = 4
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic standby_req_in,
	output logic standby_select_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int held; // Edges the present level has stood.
	// A new level waits until the old one has stood long enough.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			// The host leaves reset with the device asked to stay awake.
			standby_select_out <= 1'b1;
			held <= 0;
		end else if (standby_req_in != standby_select_out &&
			held >= HOLD_CYCLES) begin
			standby_select_out <= standby_req_in;
			held <= 0;
		end else begin
			held <= held + 1;
		end
	end
endmodule : host_pins

// ---- tb/tb_top.sv ----
/* Testbench of the pin and mode control block.
   Assumes the package and constants header are compiled first. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pin_mode_pkg::*;
	logic clk_in = 0, rst_b = 0, a = 0, b = 0, sreq = 1, stby, kill = 0;
	logic rpin = 1, buv = 0, iouv = 0, map_we = 0, cfg_we = 0, out_we = 0;
	logic cs_n = 1, avail, oe, uvd, rr;
	logic [3:0] cfg_d = 4'h0, st, cfg;
	chan_mask_t map_d = 8'h00, spi_d = 8'h00, pwm = 8'h00, ch, ma, mb;
	mode_t md;
	int n_mismatch = 0, compares = 0;
	host_pins HOST (.clk_in(clk_in), .rst_b_in(rst_b),
		.standby_req_in(sreq), .standby_select_out(stby));
	pin_mode_ctrl DUT (.clk_in(clk_in), .rst_b_in(rst_b),
		.direct_input_a_in(a), .direct_input_b_in(b),
		.standby_select_in(stby), .output_kill_pin_in(kill),
		.external_reset_pin_n_in(rpin), .battery_supply_uv_in(buv),
		.io_supply_uv_in(iouv), .map_write_in(map_we),
		.input_a_channel_map_in(map_d), .input_b_channel_map_in(map_d),
		.cfg_write_in(cfg_we), .reset_pin_oneshot_enable_in(cfg_d[0]),
		.reset_pin_persistent_enable_in(cfg_d[1]),
		.kill_pin_enable_in(cfg_d[2]),
		.battery_undervoltage_override_in(cfg_d[3]),
		.out_write_in(out_we), .spi_out_bits_in(spi_d),
		.pwm_mapped_in(pwm), .chip_select_n_in(cs_n),
		.channel_on_out(ch), .first_status_register_out(st),
		.input_a_channel_map_out(ma), .input_b_channel_map_out(mb),
		.config_out(cfg), .mode_out(md), .spi_available_out(avail),
		.serial_data_oe_out(oe), .uv_detect_enable_out(uvd),
		.register_reset_out(rr));
	initial begin
		forever #4 clk_in = ~clk_in;
	end
	// Waits n edges, then moves to the falling edge to sample.
	task automatic wt(input int n = 6);
		repeat (n) @(posedge clk_in);
		@(negedge clk_in);
	endtask : wt
	task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One strobed write: 0 maps, 1 configuration, 2 output bits.
	task automatic wr(input int k, input logic [7:0] d);
		@(posedge clk_in);
		map_we <= (k == 0);
		cfg_we <= (k == 1);
		out_we <= (k == 2);
		map_d <= d;
		cfg_d <= d[3:0];
		spi_d <= d;
		@(posedge clk_in);
		map_we <= 1'b0;
		cfg_we <= 1'b0;
		out_we <= 1'b0;
		wt();
	endtask : wr
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		repeat (2) @(posedge clk_in);
		rst_b <= 1'b1;
		wt(8);
		chk("map a", 8'h04, ma);
		chk("map b", 8'h08, mb);
		chk("uv detect", 8'h01, uvd);
		chk("avail", 8'h01, avail);
		chk("awake rr", 8'h00, rr);
		chk("awake", 8'(st_awake), md);
		wr(2, 8'h01);
		@(posedge clk_in) pwm <= 8'h40;
		a <= 1'b1;
		wt();
		chk("or", 8'h45, ch);
		chk("status", 8'h09, st);
		wr(0, 8'h20);
		@(posedge clk_in) a <= 1'b0;
		b <= 1'b1;
		wt();
		chk("overlap b", 8'h41, ch);
		@(posedge clk_in) a <= 1'b1;
		wt();
		chk("overlap a", 8'h61, ch);
		@(posedge clk_in) kill <= 1'b1;
		wt();
		chk("kill masked", 8'h61, ch);
		wr(1, 8'h04);
		chk("kill", 8'h00, ch);
		@(posedge clk_in) kill <= 1'b0;
		wt();
		chk("kill low", 8'h61, ch);
		@(posedge clk_in) rpin <= 1'b0;
		wt();
		chk("rpin masked", 8'h61, ch);
		@(posedge clk_in) rpin <= 1'b1;
		wr(1, 8'h01);
		@(posedge clk_in) rpin <= 1'b0;
		wt();
		// The one-shot reset lasts one edge; defaults then drive again.
		chk("rpin regs", 8'h4c, ch);
		chk("rpin map", 8'h04, ma);
		@(posedge clk_in) rpin <= 1'b1;
		wt();
		chk("oneshot cfg", 8'h00, cfg);
		@(posedge clk_in) rpin <= 1'b0;
		wt();
		chk("oneshot gone", 8'h4c, ch);
		@(posedge clk_in) rpin <= 1'b1;
		wr(1, 8'h02);
		@(posedge clk_in) rpin <= 1'b0;
		wt();
		chk("persist off", 8'h00, ch);
		@(posedge clk_in) rpin <= 1'b1;
		wt();
		chk("persist cfg", 8'h02, cfg);
		@(posedge clk_in) buv <= 1'b1;
		wt();
		chk("batt uv", 8'h00, ch);
		@(posedge clk_in) buv <= 1'b0;
		wt();
		chk("batt back", 8'h4c, ch);
		@(posedge clk_in) buv <= 1'b1;
		wr(1, 8'h0a);
		chk("override", 8'h4c, ch);
		@(posedge clk_in) buv <= 1'b0;
		iouv <= 1'b1;
		wt();
		chk("io avail", 8'h00, avail);
		chk("io cfg", 8'h00, cfg);
		wr(2, 8'hff);
		chk("io refused", 8'h4c, ch);
		@(posedge clk_in) iouv <= 1'b0;
		b <= 1'b0;
		sreq <= 1'b0;
		wt(10);
		chk("limp", 8'(st_limp), md);
		chk("limp ch2", 8'h01, ch[2]);
		chk("limp status", 8'h09, st);
		@(posedge clk_in) a <= 1'b0;
		cs_n <= 1'b0;
		wt(8);
		chk("sleep", 8'(st_sleep), md);
		chk("sleep rr", 8'h01, rr);
		chk("sleep uv", 8'h00, uvd);
		chk("sleep oe", 8'h00, oe);
		wr(2, 8'h01);
		@(posedge clk_in) sreq <= 1'b1;
		wt(10);
		chk("woken", 8'h40, ch);
		chk("awake oe", 8'h01, oe);
		@(posedge clk_in) cs_n <= 1'b1;
		wt(2);
		chk("idle oe", 8'h00, oe);
		wrap_up();
	end
endmodule : tb_top
